// ===== core/acs_top.sv
// Conversion sequencer top: APB registers, start control, interrupt.
//
// What this block does
// - Standby stops every conversion at once.
// - Result read is served before new write.
// - Trigger edges ignored while converting.
// - Mode or channel write beats result write.
// - Sample switch closed first tenth of conversion.
// - Channel write leaves the end flag alone.
// - Old channel flag may show after rewrite.
// - Read result before mode or channel write.
// - Stop colliding with completion drops that result.
// - Run bit with software start repeats conversions back to back.
// - Mode or channel write aborts and restarts.
// - Hardware start: one conversion per edge.
// - Reset clears the result register.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module acs_top
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby_req,
    input wire logic ext_conv_trigger,
    input wire logic cmp_in,
    output logic sample_hold_close,
    output logic [9:0] dac_code,
    output logic [2:0] channel_out,
    output logic conv_power_out,
    output logic conv_end_irq
);
    import acs_pkg::*;

    // ********************************
    // State
    // ********************************
    acs_mode_t conv_mode_reg;
    logic [2:0] channel_select_reg;
    logic [9:0] conv_result_reg;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] mask_reg;
    logic trig_prev_reg;
    logic trig_level;
    logic cmp_level;
    logic sar_busy;
    logic sar_done;
    logic sar_sample;
    logic [9:0] sar_dac;
    logic [9:0] sar_result;

    // ********************************
    // APB decode
    // ********************************
    wire sel_mode = (paddr == OFF_MODE);
    wire sel_chan = (paddr == OFF_CHAN);
    wire sel_result = (paddr == OFF_RESULT);
    wire sel_status = (paddr == OFF_STATUS);
    wire sel_mask = (paddr == OFF_MASK);
    wire addr_hit = sel_mode | sel_chan | sel_result | sel_status | sel_mask;
    wire access_first = psel && penable && !pready;
    wire wr_en = psel && penable && pready && pwrite && addr_hit;
    wire rd_capture = access_first && !pwrite;
    wire mc_wr = wr_en && (sel_mode || sel_chan);
    wire stat_w1c = wr_en && sel_status && pwdata[STAT_FLAG_BIT];
    wire [1:0] stat_rd = {sar_busy, stat_reg[STAT_FLAG_BIT]};

    wire [31:0] rd_mux =
        sel_mode ? {24'h000000, conv_mode_reg} :
        sel_chan ? {29'h0, channel_select_reg} :
        sel_result ? {22'h0, conv_result_reg} :
        sel_status ? {30'h0, stat_rd} :
        sel_mask ? {30'h0, mask_reg} : 32'h00000000;

    // ********************************
    // Start, abort and completion
    // ********************************
    wire trig_rise = trig_level && !trig_prev_reg;
    wire trig_fall = !trig_level && trig_prev_reg;
    wire trig_edge =
        (conv_mode_reg.edge_sel == EDGE_FALL) ? trig_fall :
        (conv_mode_reg.edge_sel == EDGE_RISE) ? trig_rise :
        (trig_rise | trig_fall);

    // A stop request in the completion cycle drops that result.
    wire abort_conv = sar_busy &&
        (mc_wr || standby_req || !conv_mode_reg.run);
    wire start_ok = conv_mode_reg.hw_start_select ? trig_edge : 1'b1;
    wire start_conv = !sar_busy && conv_mode_reg.run && !standby_req &&
        !mc_wr && start_ok;
    wire done_valid = sar_done && !abort_conv;

    always_comb begin
        stat_next = stat_reg;
        if (stat_w1c) begin
            stat_next[STAT_FLAG_BIT] = 1'b0;
        end
        // Hardware set wins over a clear in the same cycle.
        if (done_valid) begin
            stat_next[STAT_FLAG_BIT] = 1'b1;
        end
    end

    // ********************************
    // Submodules
    // ********************************
    acs_sync u_trig_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_conv_trigger),
        .level(trig_level)
    );

    acs_sync u_cmp_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(cmp_in),
        .level(cmp_level)
    );

    acs_sar u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_conv),
        .abort(abort_conv),
        .cmp_bit(cmp_level),
        .busy(sar_busy),
        .sample_on(sar_sample),
        .dac_code(sar_dac),
        .done(sar_done),
        .result(sar_result)
    );

    // ********************************
    // Bus slave
    // ********************************
    // Read data is taken on the first access edge, the same edge on which
    // a result write could land, so the old value is returned.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access_first;
            pslverr <= access_first && !addr_hit;
            if (rd_capture) begin
                prdata <= rd_mux;
            end
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_mode_reg <= MODE_RST;
            channel_select_reg <= CHAN_RST;
            mask_reg <= STAT_RST;
        end else if (wr_en) begin
            if (sel_mode) begin
                conv_mode_reg <= pwdata[7:0] & 8'hc7;
            end
            if (sel_chan) begin
                channel_select_reg <= pwdata[2:0];
            end
            if (sel_mask) begin
                mask_reg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_result_reg <= RESULT_RST;
        end else if (done_valid) begin
            conv_result_reg <= sar_result;
        end
    end

    // The flag is only cleared by its own write-one, never by a
    // channel rewrite, so a flag already set for the old channel still shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= STAT_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_reg <= 1'b0;
            conv_end_irq <= 1'b0;
            sample_hold_close <= 1'b0;
            dac_code <= 10'h000;
            channel_out <= CHAN_RST;
            conv_power_out <= 1'b0;
        end else begin
            trig_prev_reg <= trig_level;
            conv_end_irq <= |(stat_next & mask_reg);
            sample_hold_close <= sar_sample;
            dac_code <= sar_dac;
            channel_out <= channel_select_reg;
            conv_power_out <= conv_mode_reg.power;
        end
    end

    // ********************************
    // Checks
    // ********************************
    property p_result_store;
        @(posedge pclk) disable iff (!presetn)
        done_valid |=> conv_result_reg == $past(sar_result)
            && stat_reg[STAT_FLAG_BIT];
    endproperty
    a_result_store: assert property (p_result_store)
        else $error("Result or flag not stored at conversion end.");

    property p_write_wins;
        @(posedge pclk) disable iff (!presetn)
        sar_done && mc_wr |=> conv_result_reg == $past(conv_result_reg);
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("Result written despite register write.");

    property p_read_first;
        @(posedge pclk) disable iff (!presetn)
        rd_capture && sel_result && sar_done |=>
            prdata[9:0] == $past(conv_result_reg);
    endproperty
    a_read_first: assert property (p_read_first)
        else $error("Read returned the new result.");

    property p_trig_ignored;
        @(posedge pclk) disable iff (!presetn)
        sar_busy && trig_edge |-> !start_conv;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored)
        else $error("Trigger taken during conversion.");

    property p_standby_stop;
        @(posedge pclk) disable iff (!presetn)
        standby_req |=> !sar_busy;
    endproperty
    a_standby_stop: assert property (p_standby_stop)
        else $error("Conversion running in standby.");

    property p_chan_keeps_flag;
        @(posedge pclk) disable iff (!presetn)
        wr_en && sel_chan && stat_reg[STAT_FLAG_BIT] |=>
            stat_reg[STAT_FLAG_BIT];
    endproperty
    a_chan_keeps_flag: assert property (p_chan_keeps_flag)
        else $error("Channel write cleared the end flag.");

    property p_abort_restart;
        @(posedge pclk) disable iff (!presetn)
        mc_wr && sar_busy |=> !sar_busy;
    endproperty
    a_abort_restart: assert property (p_abort_restart)
        else $error("Register write did not abort conversion.");

    property p_hw_single;
        @(posedge pclk) disable iff (!presetn)
        done_valid && conv_mode_reg.hw_start_select ##1 !trig_edge
            |-> ##1 !sar_busy;
    endproperty
    a_hw_single: assert property (p_hw_single)
        else $error("Hardware mode restarted without a trigger.");

    property p_sw_repeat;
        @(posedge pclk) disable iff (!presetn)
        done_valid && !conv_mode_reg.hw_start_select ##1
            (conv_mode_reg.run && !standby_req && !mc_wr) |=> sar_busy;
    endproperty
    a_sw_repeat: assert property (p_sw_repeat)
        else $error("Software mode did not repeat.");

    // A clear that meets a conversion end must not hide that end.
    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        done_valid && stat_w1c |=> stat_reg[STAT_FLAG_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Flag clear beat a conversion end.");

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        stat_w1c && !done_valid |=> !stat_reg[STAT_FLAG_BIT];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("Write-one did not clear the end flag.");

    property p_irq_set;
        @(posedge pclk) disable iff (!presetn)
        done_valid && mask_reg[STAT_FLAG_BIT] |=> conv_end_irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("Unmasked conversion end raised no interrupt.");

    property p_run_stop;
        @(posedge pclk) disable iff (!presetn)
        sar_busy && !conv_mode_reg.run |=> !sar_busy;
    endproperty
    a_run_stop: assert property (p_run_stop)
        else $error("Conversion kept running after run cleared.");

    property p_write_no_flag;
        @(posedge pclk) disable iff (!presetn)
        sar_done && mc_wr && !stat_reg[STAT_FLAG_BIT] |=>
            !stat_reg[STAT_FLAG_BIT];
    endproperty
    a_write_no_flag: assert property (p_write_no_flag)
        else $error("End flag raised despite register write.");

    property p_sample_pin;
        @(posedge pclk) disable iff (!presetn)
        sar_sample |=> sample_hold_close;
    endproperty
    a_sample_pin: assert property (p_sample_pin)
        else $error("Sample switch not closed during sampling.");

    c_sw_conv: cover property (@(posedge pclk) disable iff (!presetn)
        done_valid && !conv_mode_reg.hw_start_select);
    c_hw_conv: cover property (@(posedge pclk) disable iff (!presetn)
        done_valid && conv_mode_reg.hw_start_select);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn)
        sar_done && mc_wr);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(conv_end_irq));
    c_trig_busy: cover property (@(posedge pclk) disable iff (!presetn)
        sar_busy && trig_edge);
endmodule

// ===== core/acs_pkg.sv
// Package of constants and types for the conversion sequencer.
package acs_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CHAN = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [1:0] STAT_RST = 2'h0;

    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    // Edge selection for the trigger pin.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_CYCLES = CONV_CYCLES / 10;
    localparam int RES_BITS = 10;
    localparam int BIT_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / RES_BITS;
    localparam int CNT_W = 8;
    localparam int PWR_WAIT_NS = 14000;
    localparam int PWR_WAIT_CYCLES =
        (PWR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic run;
        logic hw_start_select;
        logic [2:0] unused;
        logic [1:0] edge_sel;
        logic power;
    } acs_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } acs_state_t;

endpackage

// ===== core/acs_sync.sv
// Three-stage synchroniser for a pin with agreement filter.
`timescale 1ns/1ps
module acs_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // The output moves only when the last two stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end
endmodule

// ===== core/acs_sar.sv
// Successive approximation engine with sample phase.
`timescale 1ns/1ps
module acs_sar
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp_bit,
    output logic busy,
    output logic sample_on,
    output logic [9:0] dac_code,
    output logic done,
    output logic [9:0] result
);
    acs_state_t state_reg;
    acs_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [3:0] bit_reg;
    wire tick = (cnt_reg == '0);
    wire [9:0] decided = cmp_bit ? dac_code : dac_code & ~(10'h001 << bit_reg);

    assign busy = (state_reg != ST_IDLE);
    assign done = (state_reg == ST_CONVERT) && tick && (bit_reg == 4'h0);
    assign result = decided;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (start) state_next = ST_SAMPLE;
            ST_SAMPLE: if (tick) state_next = ST_CONVERT;
            ST_CONVERT: if (done) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (abort) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            bit_reg <= 4'h0;
            dac_code <= 10'h000;
            sample_on <= 1'b0;
        end else begin
            state_reg <= state_next;
            sample_on <= (state_next == ST_SAMPLE);
            if (state_reg == ST_IDLE) begin
                cnt_reg <= CNT_W'(SAMPLE_CYCLES - 1);
            end else if (!tick) begin
                cnt_reg <= cnt_reg - 1'b1;
            end else if (state_reg == ST_SAMPLE) begin
                cnt_reg <= CNT_W'(BIT_CYCLES - 1);
                bit_reg <= 4'(RES_BITS - 1);
                dac_code <= 10'h200;
            end else begin
                cnt_reg <= CNT_W'(BIT_CYCLES - 1);
                bit_reg <= bit_reg - 1'b1;
                dac_code <= decided | ((10'h001 << bit_reg) >> 1);
            end
        end
    end

    property p_sample_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(sample_on) && !abort ##1 (!abort)[*8] |-> sample_on;
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("Sample phase shorter than expected.");
endmodule

// ===== testbench/acs_analog.sv
// Far-side model: analog channel levels, comparator and trigger pin.
`timescale 1ns/1ps
module acs_analog (
    input wire logic pclk,
    input wire logic sample_hold_close,
    input wire logic [9:0] dac_code,
    input wire logic [2:0] channel_out,
    input wire logic trig_level,
    output logic cmp_in,
    output logic ext_conv_trigger
);
    logic [9:0] held;

    initial held = 10'h000;

    // The held level only follows the channel while the switch is closed.
    // This exposes a sequencer that compares before sampling has ended.
    always @(posedge pclk) begin
        if (sample_hold_close === 1'b1) begin
            held <= {channel_out, 7'h35};
        end
    end

    // No digital read of the shared pins is modelled during conversion.
    assign cmp_in = (held >= dac_code);
    assign ext_conv_trigger = trig_level;
endmodule

// ===== testbench/adc_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
    import acs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic standby_req, trig_level, ext_conv_trigger, cmp_in;
    logic sample_hold_close, conv_power_out, conv_end_irq;
    logic [9:0] dac_code;
    logic [2:0] channel_out;
    int fails, checked, n, sh;
    logic ok;

    acs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_req(standby_req),
        .ext_conv_trigger(ext_conv_trigger), .cmp_in(cmp_in),
        .sample_hold_close(sample_hold_close), .dac_code(dac_code),
        .channel_out(channel_out), .conv_power_out(conv_power_out),
        .conv_end_irq(conv_end_irq));

    acs_analog far (.pclk(pclk), .sample_hold_close(sample_hold_close),
        .dac_code(dac_code), .channel_out(channel_out),
        .trig_level(trig_level), .cmp_in(cmp_in),
        .ext_conv_trigger(ext_conv_trigger));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ********************************
    // Shared tasks
    // ********************************
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one edge after the edge of pready.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            fails++;
            stop_test;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next setup off this time step.
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task rd(input logic [7:0] a);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask

    // Counts cycles to the interrupt and the cycles of closed switch.
    task wait_irq;
        n = 0;
        sh = 0;
        do begin
            @(posedge pclk);
            n++;
            if (sample_hold_close === 1'b1) sh++;
        end while (conv_end_irq !== 1'b1 && n < 400);
        if (conv_end_irq !== 1'b1) begin
            fails++;
            stop_test;
        end
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task t_reset;
        logic e;
        rd(OFF_RESULT);
        check("result after reset", q, 32'h0000_0000);
        rd(OFF_MODE);
        check("mode after reset", q, 32'h0000_0000);
        rd(OFF_STATUS);
        check("status after reset", q, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000, q, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", q, 32'h0000_0000);
        wr(OFF_RESULT, 32'h0000_03ff);
        rd(OFF_RESULT);
        check("result read only", q, 32'h0000_0000);
        $display("reset test done");
    endtask

    task t_soft;
        wr(OFF_MASK, 32'h1);
        wr(OFF_CHAN, 32'h5);
        wr(OFF_MODE, 32'h01);
        repeat (PWR_WAIT_CYCLES) @(posedge pclk);
        wr(OFF_MODE, 32'h81);
        wait_irq;
        check("sample cycles", sh, SAMPLE_CYCLES);
        ok = n >= CONV_CYCLES && n <= CONV_CYCLES + 4;
        check("conv time", ok, 1'b1);
        check("channel out", channel_out, 32'h5);
        rd(OFF_RESULT);
        check("result ch5", q, 32'h0000_02b5);
        wr(OFF_STATUS, 32'h1);
        wait_irq;
        check("repeat time", n <= CONV_CYCLES + 4, 1);
        wr(OFF_CHAN, 32'h2);
        rd(OFF_STATUS);
        check("flag kept", q[0], 32'h1);
        $display("software start test done");
    endtask

    task t_abort;
        wr(OFF_STATUS, 32'h1);
        repeat (50) @(posedge pclk);
        wr(OFF_CHAN, 32'h3);
        wait_irq;
        check("restart time", n >= CONV_CYCLES, 1);
        rd(OFF_RESULT);
        check("result ch3", q, 32'h0000_01b5);
        $display("abort test done");
    endtask

    task t_standby;
        standby_req <= 1'b1;
        wr(OFF_STATUS, 32'h1);
        repeat (150) @(posedge pclk);
        check("irq in standby", conv_end_irq, 1'b0);
        rd(OFF_STATUS);
        check("idle in standby", q, 32'h0000_0000);
        standby_req <= 1'b0;
        wait_irq;
        ok = n >= CONV_CYCLES;
        check("resume", ok, 1'b1);
        wr(OFF_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq masked", conv_end_irq, 1'b0);
        wr(OFF_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq unmasked", conv_end_irq, 1'b1);
        wr(OFF_MODE, 32'h0);
        wr(OFF_STATUS, 32'h1);
        repeat (150) @(posedge pclk);
        check("stopped", conv_end_irq, 1'b0);
        $display("standby test done");
    endtask

    task t_hw;
        wr(OFF_MODE, 32'h01);
        repeat (PWR_WAIT_CYCLES) @(posedge pclk);
        check("power out", conv_power_out, 1'b1);
        wr(OFF_MODE, 32'hc3);
        repeat (20) @(posedge pclk);
        rd(OFF_STATUS);
        check("waits for edge", q, 32'h0000_0000);
        trig_level <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 40) trig_level <= 1'b0;
            if (n == 60) trig_level <= 1'b1;
        end while (conv_end_irq !== 1'b1 && n < 400);
        if (conv_end_irq !== 1'b1) begin
            fails++;
            stop_test;
        end
        ok = n >= CONV_CYCLES && n <= CONV_CYCLES + 8;
        check("hw time", ok, 1'b1);
        rd(OFF_RESULT);
        check("hw result", q, 32'h0000_01b5);
        wr(OFF_STATUS, 32'h1);
        trig_level <= 1'b0;
        repeat (200) @(posedge pclk);
        check("one per edge", conv_end_irq, 1'b0);
        wr(OFF_MODE, 32'h0);
        $display("hardware start test done");
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test;
    end

    initial begin
        fails = 0;
        checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        standby_req = 1'b0;
        trig_level = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_soft;
        t_abort;
        t_standby;
        t_hw;
        stop_test;
    end
endmodule
